// ### core/ccu_map.vh
// register map, field positions, reset values and timing counts
`ifndef CCU_MAP_VH
`define CCU_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define T2_CTRL_OFF    12'h000
`define T2_COUNT_OFF   12'h004
`define CT_CTRL_OFF    12'h008
`define CT_COUNT_OFF   12'h00C
`define CT_RELOAD_OFF  12'h010
`define CM_SELECT_OFF  12'h014
`define CM_ENABLE_OFF  12'h018
`define CC_MODE_OFF    12'h01C
`define CMP_LEVEL_OFF  12'h020
`define PORT5_CTRL_OFF 12'h024
`define IRQ_STAT_OFF   12'h028
`define IRQ_MASK_OFF   12'h02C
`define OUT_STATE_OFF  12'h030
`define CMP_BASE_OFF   12'h040
`define CMP_LAST_IDX   4'd12

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define T2_RUN_BIT      0
`define T2_PRE_LSB      1
`define T2_RLD_MODE_BIT 3
`define T2_RLD_EN_BIT   4
`define CT_RUN_BIT      0
`define CT_PRE_LSB      8
`define CC_MODE_OFFV    2'b00
`define CC_MODE_CMP     2'b01
`define CC_MODE_CAPPIN  2'b10
`define CC_MODE_CAPWR   2'b11
`define CC_CMODE_LSB    10

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define REG_RESET      32'h0000_0000
`define T2_BASE_DIV    4'd12
`define CT_BASE_DIV    1'd1
`define CNT_MAX        16'hFFFF
`define NUM_CMP        13
`define NUM_CC         5

`endif

// ### core/compare_slot.v
// one compare channel: match detection, mode 0/1 output, shadow latch
`timescale 1ns/10ps
module compare_slot (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [15:0] timer_cnt,
   input  wire        timer_upd,
   input  wire        timer_ovf,
   input  wire [15:0] cmp_value,
   input  wire        enable,
   input  wire        mode1,
   input  wire        use_shadow,
   input  wire        level,
   output wire        match,
   output reg         out_ff
);

   reg  [15:0] shadow_ff;
   wire [15:0] active_val;

   // shadow only follows the register at overflow so a late write
   // cannot make the current period miss its match
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_ff <= 16'h0000;
      end else if (timer_ovf) begin
         shadow_ff <= cmp_value;
      end
   end

   // in the overflow cycle the latch is being reloaded, so the new
   // period already compares against the value it takes on
   assign active_val = (use_shadow && !timer_ovf) ? shadow_ff
                                                  : cmp_value;
   assign match      = enable & timer_upd & (timer_cnt == active_val);

   // match beats overflow when both land together
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= 1'b0;
      end else if (mode1) begin
         if (match) begin
            out_ff <= level;
         end
      end else if (match) begin
         out_ff <= 1'b1;
      end else if (timer_ovf) begin
         out_ff <= 1'b0;
      end
   end

endmodule

// ### core/compare_capture_block.v
// compare/capture block: two timebases, thirteen compare slots, apb
//
// Notes on behaviour
// - 16-bit general timer, 2-bit prescaler, reload, base rate clock/12.
// - 16-bit compare timer, 8-bit prescaler, reload, base rate clock/2.
// - thirteen 16-bit compare registers matched against their timebase.
// - five of them can capture the general timer instead.
// - up to twenty-one port lines driven by compare results.
// - timer and compare/capture events raise interrupt requests.
// - each general compare register selects general or compare timer.
// - capture-capable registers always use the general timer.
// - reload/capture register compares and supplies the timer reload.
// - reload/capture and four cc registers drive or sense port 1 bits 0-4.
// - fourth cc register can drive all port 5 bits in mode 1.
// - general compare on general timer: mode 1, drives port 4.
// - general compare on compare timer: mode 0 with shadow latches.
// - mode 0: match sets output high, next overflow clears it.
// - mode 1: match drives preset level, overflow leaves it.
// - shadow latches reload from compare registers at each overflow.
// - capture on input edge or on software write to the register.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "ccu_map.vh"
module compare_capture_block (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [4:0]  capture_in,
   input  wire        reload_trig_in,
   output wire [4:0]  port1_cmp_out,
   output wire [7:0]  port4_cmp_out,
   output reg  [7:0]  port5_cmp_out,
   output reg         irq
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [4:0]  t2_ctrl_ff;
   reg  [15:0] t2_cnt_ff;
   reg  [15:0] ct_ctrl_ff;
   reg  [15:0] ct_cnt_ff;
   reg  [15:0] ct_reload_ff;
   reg  [7:0]  cm_select_ff;
   reg  [7:0]  cm_enable_ff;
   reg  [14:0] cc_mode_ff;
   reg  [15:0] cmp_level_ff;
   reg  [15:0] port5_ctrl_ff;
   reg  [15:0] irq_stat_ff;
   reg  [15:0] irq_mask_ff;
   reg  [15:0] cmp_ff [0:12];
   reg  [3:0]  t2_base_ff;
   reg  [2:0]  t2_pre_ff;
   reg         ct_base_ff;
   reg  [7:0]  ct_pre_ff;
   reg         t2_upd_ff;
   reg         t2_ovf_ff;
   reg         ct_upd_ff;
   reg         ct_ovf_ff;
   reg  [4:0]  cap_prev_ff;
   reg         trig_prev_ff;
   reg  [31:0] nxt_rdata;
   reg         nxt_err;

   wire        access;
   wire        wr_en;
   wire        cmp_hit;
   wire [3:0]  cmp_idx;
   wire        t2_tick;
   wire        ct_tick;
   wire [4:0]  cap_edge;
   wire        trig_fall;
   wire [12:0] slot_match;
   wire [12:0] slot_out;
   wire [4:0]  cap_evt;
   wire [15:0] irq_set;
   wire [15:0] t2_reload_val;
   wire [2:0]  t2_pre_lim;

   // ---------------------------------------------------------------
   // apb slave: one wait state, so pready and prdata are flops
   // ---------------------------------------------------------------
   assign access  = psel & penable & pready;
   assign wr_en   = access & pwrite;
   assign cmp_idx = paddr[5:2];
   assign cmp_hit = (paddr[11:6] == 6'b000001) &&
                    (cmp_idx <= `CMP_LAST_IDX) && (paddr[1:0] == 2'b00);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= `REG_RESET;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= nxt_rdata;
         pslverr <= psel & penable & ~pready & nxt_err;
      end
   end

   always @* begin
      nxt_rdata = `REG_RESET;
      nxt_err   = 1'b0;
      if (cmp_hit) begin
         nxt_rdata = {16'h0000, cmp_ff[cmp_idx]};
      end else begin
         case (paddr)
            `T2_CTRL_OFF:    nxt_rdata = {27'h0, t2_ctrl_ff};
            `T2_COUNT_OFF:   nxt_rdata = {16'h0000, t2_cnt_ff};
            `CT_CTRL_OFF:    nxt_rdata = {16'h0000, ct_ctrl_ff};
            `CT_COUNT_OFF:   nxt_rdata = {16'h0000, ct_cnt_ff};
            `CT_RELOAD_OFF:  nxt_rdata = {16'h0000, ct_reload_ff};
            `CM_SELECT_OFF:  nxt_rdata = {24'h0, cm_select_ff};
            `CM_ENABLE_OFF:  nxt_rdata = {24'h0, cm_enable_ff};
            `CC_MODE_OFF:    nxt_rdata = {17'h0, cc_mode_ff};
            `CMP_LEVEL_OFF:  nxt_rdata = {16'h0000, cmp_level_ff};
            `PORT5_CTRL_OFF: nxt_rdata = {16'h0000, port5_ctrl_ff};
            `IRQ_STAT_OFF:   nxt_rdata = {16'h0000, irq_stat_ff};
            `IRQ_MASK_OFF:   nxt_rdata = {16'h0000, irq_mask_ff};
            `OUT_STATE_OFF:  nxt_rdata = {11'h0, port5_cmp_out,
                                          port4_cmp_out, port1_cmp_out};
            default:         nxt_err   = 1'b1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t2_ctrl_ff    <= 5'h00;
         ct_ctrl_ff    <= 16'h0000;
         ct_reload_ff  <= 16'h0000;
         cm_select_ff  <= 8'h00;
         cm_enable_ff  <= 8'h00;
         cc_mode_ff    <= 15'h0000;
         cmp_level_ff  <= 16'h0000;
         port5_ctrl_ff <= 16'h0000;
         irq_mask_ff   <= 16'h0000;
      end else if (wr_en) begin
         case (paddr)
            `T2_CTRL_OFF:    t2_ctrl_ff    <= pwdata[4:0];
            `CT_CTRL_OFF:    ct_ctrl_ff    <= pwdata[15:0];
            `CT_RELOAD_OFF:  ct_reload_ff  <= pwdata[15:0];
            `CM_SELECT_OFF:  cm_select_ff  <= pwdata[7:0];
            `CM_ENABLE_OFF:  cm_enable_ff  <= pwdata[7:0];
            `CC_MODE_OFF:    cc_mode_ff    <= pwdata[14:0];
            `CMP_LEVEL_OFF:  cmp_level_ff  <= pwdata[15:0];
            `PORT5_CTRL_OFF: port5_ctrl_ff <= pwdata[15:0];
            `IRQ_MASK_OFF:   irq_mask_ff   <= pwdata[15:0];
            default:         cmp_level_ff  <= cmp_level_ff;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // general timer: clock/12 base, then 1/2/4/8 prescale
   // ---------------------------------------------------------------
   assign t2_pre_lim = (3'd1 << t2_ctrl_ff[`T2_PRE_LSB+1:`T2_PRE_LSB])
                       - 3'd1;
   assign t2_tick    = t2_ctrl_ff[`T2_RUN_BIT] &&
                       (t2_base_ff == `T2_BASE_DIV - 4'd1) &&
                       (t2_pre_ff == t2_pre_lim);
   assign t2_reload_val = t2_ctrl_ff[`T2_RLD_EN_BIT] ? cmp_ff[0]
                                                     : 16'h0000;
   assign trig_fall  = trig_prev_ff & ~reload_trig_in;
   assign cap_edge   = capture_in & ~cap_prev_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t2_base_ff   <= 4'd0;
         t2_pre_ff    <= 3'd0;
         t2_cnt_ff    <= 16'h0000;
         t2_upd_ff    <= 1'b0;
         t2_ovf_ff    <= 1'b0;
         trig_prev_ff <= 1'b0;
         cap_prev_ff  <= 5'h00;
      end else begin
         trig_prev_ff <= reload_trig_in;
         cap_prev_ff  <= capture_in;
         t2_upd_ff    <= t2_tick;
         t2_ovf_ff    <= t2_tick && (t2_cnt_ff == `CNT_MAX);
         if (t2_ctrl_ff[`T2_RUN_BIT]) begin
            if (t2_base_ff == `T2_BASE_DIV - 4'd1) begin
               t2_base_ff <= 4'd0;
               t2_pre_ff  <= (t2_pre_ff == t2_pre_lim) ? 3'd0
                                                       : t2_pre_ff + 3'd1;
            end else begin
               t2_base_ff <= t2_base_ff + 4'd1;
            end
         end
         if (wr_en && paddr == `T2_COUNT_OFF) begin
            t2_cnt_ff <= pwdata[15:0];
         end else if (t2_ctrl_ff[`T2_RLD_MODE_BIT] &&
                      t2_ctrl_ff[`T2_RLD_EN_BIT] && trig_fall) begin
            t2_cnt_ff <= cmp_ff[0];
         end else if (t2_tick) begin
            if (t2_cnt_ff == `CNT_MAX) begin
               t2_cnt_ff <= t2_ctrl_ff[`T2_RLD_MODE_BIT] ? 16'h0000
                                                         : t2_reload_val;
            end else begin
               t2_cnt_ff <= t2_cnt_ff + 16'd1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // compare timer: clock/2 base, divide by prescale+1, auto reload
   // ---------------------------------------------------------------
   assign ct_tick = ct_ctrl_ff[`CT_RUN_BIT] && ct_base_ff &&
                    (ct_pre_ff == 8'd0);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ct_base_ff <= 1'b0;
         ct_pre_ff  <= 8'd0;
         ct_cnt_ff  <= 16'h0000;
         ct_upd_ff  <= 1'b0;
         ct_ovf_ff  <= 1'b0;
      end else begin
         ct_upd_ff <= ct_tick;
         ct_ovf_ff <= ct_tick && (ct_cnt_ff == `CNT_MAX);
         if (ct_ctrl_ff[`CT_RUN_BIT]) begin
            ct_base_ff <= ~ct_base_ff;
            if (ct_base_ff) begin
               ct_pre_ff <= (ct_pre_ff == 8'd0)
                            ? ct_ctrl_ff[`CT_PRE_LSB+7:`CT_PRE_LSB]
                            : ct_pre_ff - 8'd1;
            end
         end
         if (wr_en && paddr == `CT_COUNT_OFF) begin
            ct_cnt_ff <= pwdata[15:0];
         end else if (ct_tick) begin
            ct_cnt_ff <= (ct_cnt_ff == `CNT_MAX) ? ct_reload_ff
                                                 : ct_cnt_ff + 16'd1;
         end
      end
   end

   // ---------------------------------------------------------------
   // compare/capture storage; a pin capture beats a same-cycle write
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `NUM_CMP; g = g + 1) begin : slot
         wire cap_now;
         wire sw_wr;
         assign sw_wr = wr_en && cmp_hit && (cmp_idx == g);
         if (g < `NUM_CC) begin : cc
            wire [1:0] fn;
            assign fn      = cc_mode_ff[2*g+1:2*g];
            assign cap_now = ((fn == `CC_MODE_CAPPIN) && cap_edge[g]) ||
                             ((fn == `CC_MODE_CAPWR) && sw_wr);
            assign cap_evt[g] = cap_now;
            // capture source is fixed to the general timer
            compare_slot u_slot (
               .pclk       (pclk),
               .presetn    (presetn),
               .timer_cnt  (t2_cnt_ff),
               .timer_upd  (t2_upd_ff),
               .timer_ovf  (t2_ovf_ff),
               .cmp_value  (cmp_ff[g]),
               .enable     (fn == `CC_MODE_CMP),
               .mode1      (cc_mode_ff[`CC_CMODE_LSB+g]),
               .use_shadow (1'b0),
               .level      (cmp_level_ff[g]),
               .match      (slot_match[g]),
               .out_ff     (slot_out[g])
            );
         end else begin : cm
            wire on_ct;
            assign on_ct   = cm_select_ff[g-`NUM_CC];
            assign cap_now = 1'b0;
            compare_slot u_slot (
               .pclk       (pclk),
               .presetn    (presetn),
               .timer_cnt  (on_ct ? ct_cnt_ff : t2_cnt_ff),
               .timer_upd  (on_ct ? ct_upd_ff : t2_upd_ff),
               .timer_ovf  (on_ct ? ct_ovf_ff : t2_ovf_ff),
               .cmp_value  (cmp_ff[g]),
               .enable     (cm_enable_ff[g-`NUM_CC]),
               .mode1      (~on_ct),
               .use_shadow (on_ct),
               .level      (cmp_level_ff[g+3]),
               .match      (slot_match[g]),
               .out_ff     (slot_out[g])
            );
         end
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmp_ff[g] <= 16'h0000;
            end else if (cap_now) begin
               cmp_ff[g] <= t2_cnt_ff;
            end else if (sw_wr) begin
               cmp_ff[g] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   assign port1_cmp_out = slot_out[4:0];
   assign port4_cmp_out = slot_out[12:5];

   // ---------------------------------------------------------------
   // port 5 lines follow the fourth cc register in mode 1 only
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port5_cmp_out <= 8'h00;
      end else if (slot_match[4] && cc_mode_ff[`CC_CMODE_LSB+4]) begin
         port5_cmp_out <= (port5_cmp_out & ~port5_ctrl_ff[7:0]) |
                          (port5_ctrl_ff[15:8] & port5_ctrl_ff[7:0]);
      end
   end

   // ---------------------------------------------------------------
   // interrupts: sticky status, write one to clear, set wins
   // ---------------------------------------------------------------
   assign irq_set = {slot_match[12:5], ct_ovf_ff,
                     cap_evt | slot_match[4:0],
                     trig_fall & t2_ctrl_ff[`T2_RLD_MODE_BIT],
                     t2_ovf_ff};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= 16'h0000;
         irq         <= 1'b0;
      end else begin
         if (wr_en && paddr == `IRQ_STAT_OFF) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[15:0]) | irq_set;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
         end
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

endmodule

// ### bench/ccu_checker.sv
// port-level assertions for the compare/capture block
`timescale 1ns/10ps
module ccu_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [4:0]  port1_cmp_out,
   input wire logic [7:0]  port4_cmp_out,
   input wire logic [7:0]  port5_cmp_out,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ------------------------------------------
   // bus answer
   // ------------------------------------------
   property p_ack_wait;
      psel && !penable |=> ##[0:2] pready;
   endproperty
   a_ack_wait: assert property (p_ack_wait) else $error("no answer");
   property p_ack_one;
      pready |=> !pready;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ready too long");
   property p_ack_req;
      pready |-> psel && penable;
   endproperty
   a_ack_req: assert property (p_ack_req) else $error("ready unasked");
   // one wait state: access must already stand a cycle before
   property p_ack_late;
      pready |-> $past(psel) && $past(penable);
   endproperty
   a_ack_late: assert property (p_ack_late) else $error("ready early");
   property p_err_ack;
      pslverr |-> pready;
   endproperty
   a_err_ack: assert property (p_err_ack) else $error("lone error");
   property p_err_rd;
      pslverr && !pwrite |-> prdata == 32'h0000_0000;
   endproperty
   a_err_rd: assert property (p_err_rd) else $error("refused read data");

   // ------------------------------------------
   // outputs
   // ------------------------------------------
   property p_quiet;
      $rose(presetn) |-> !irq && port1_cmp_out == 5'h00
         && port4_cmp_out == 8'h00 && port5_cmp_out == 8'h00;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs after reset");
   // irq only drops after software clears status or mask
   property p_irq_drop;
      $fell(irq) |-> $past(pready && pwrite, 1)
         || $past(pready && pwrite, 2) || $past(pready && pwrite, 3);
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("irq dropped alone");

   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
   c_p5: cover property ($rose(port5_cmp_out[0]));
endmodule

bind compare_capture_block ccu_checker u_chk (.*);

// ### bench/pin_model.sv
// pin-side partner: drives the capture and external reload pins
`timescale 1ns/10ps
module pin_model (
   input  wire logic  pclk,
   output logic [4:0] capture_in,
   output logic       reload_trig_in
);
   initial begin
      capture_in = 5'h00;
      reload_trig_in = 1'b1;
   end

   // held two cycles so the edge detector sees the edge
   task cap(input int n);
      @(posedge pclk);
      capture_in[n] <= 1'b1;
      repeat (2) @(posedge pclk);
      capture_in[n] <= 1'b0;
   endtask

   task fall;
      @(posedge pclk);
      reload_trig_in <= 1'b0;
      repeat (2) @(posedge pclk);
      reload_trig_in <= 1'b1;
   endtask
endmodule

// ### bench/compare_capture_block_test.sv
// self-checking bench for the compare/capture block
`timescale 1ns/10ps
module compare_capture_block_test;
   typedef struct {
      logic [11:0] a;
      logic [31:0] w;
      logic [31:0] e;
      logic        s;
   } row_t;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, r;
   wire  [31:0] prdata;
   wire         pready, pslverr, irq, reload_trig_in;
   wire  [4:0]  capture_in, port1_cmp_out;
   wire  [7:0]  port4_cmp_out, port5_cmp_out;
   wire  [21:0] outs = {irq, port5_cmp_out, port4_cmp_out, port1_cmp_out};
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          i;
   row_t        rows[4] = '{
      '{12'h070, 32'hFFFF_1234, 32'h0000_1234, 1'b0},
      '{12'h040, 32'h0000_BEEF, 32'h0000_BEEF, 1'b0},
      '{12'h03C, 32'h1234_5678, 32'h0000_0000, 1'b1},
      '{12'h02C, 32'h0000_0000, 32'h0000_0000, 1'b0}};

   compare_capture_block u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_in(capture_in),
      .reload_trig_in(reload_trig_in), .port1_cmp_out(port1_cmp_out),
      .port4_cmp_out(port4_cmp_out), .port5_cmp_out(port5_cmp_out),
      .irq(irq));
   pin_model u_pins (
      .pclk(pclk), .capture_in(capture_in),
      .reload_trig_in(reload_trig_in));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         results;
      end
   end

   task results;
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // bounded wait on one output bit, then compare
   task wt(input int b, input logic v);
      for (int k = 0; k < 600 && outs[b] !== v; k++) @(posedge pclk);
      chk(32'(outs[b]), 32'(v));
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 13; i++) begin
         rd(12'(4 * i));
         chk(r, 32'h0000_0000);
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk(r, rows[i].e);
         chk(32'(err), 32'(rows[i].s));
      end
      // ------------------------------------------
      // mode 1 on the general timer, interrupt
      // ------------------------------------------
      wr(12'h020, 32'h0000_0100);
      wr(12'h018, 32'h0000_0001);
      wr(12'h054, 32'h0000_0011);
      wr(12'h02C, 32'h0000_0100);
      wr(12'h004, 32'h0000_0010);
      wr(12'h000, 32'h0000_0001);
      wt(5, 1'b1);
      wt(21, 1'b1);
      rd(12'h028);
      chk(r & 32'h0000_0100, 32'h0000_0100);
      wr(12'h004, 32'h0000_FFFE);
      r = 32'h0000_0000;
      for (i = 0; i < 30 && r[0] !== 1'b1; i++) rd(12'h028);
      chk(32'(outs[5]), 32'h0000_0001);
      wr(12'h028, 32'h0000_0101);
      wr(12'h000, 32'h0000_0000);
      wt(21, 1'b0);
      // ------------------------------------------
      // mode 0 on the compare timer
      // ------------------------------------------
      wr(12'h014, 32'h0000_0002);
      wr(12'h018, 32'h0000_0003);
      wr(12'h058, 32'h0000_0002);
      wr(12'h00C, 32'h0000_FFFE);
      wr(12'h008, 32'h0000_0001);
      wt(6, 1'b1);
      wr(12'h058, 32'h0000_0020);
      wr(12'h00C, 32'h0000_FFFE);
      wt(6, 1'b0);
      // a mid-period write must wait for the next overflow
      wr(12'h058, 32'h0000_0010);
      repeat (40) @(posedge pclk);
      chk(32'(outs[6]), 32'h0000_0000);
      wt(6, 1'b1);
      chk(32'(outs[5]), 32'h0000_0001);
      wr(12'h008, 32'h0000_0000);
      // ------------------------------------------
      // capture on pin and on write, reload
      // ------------------------------------------
      wr(12'h004, 32'h0000_0100);
      wr(12'h01C, 32'h0000_0038);
      u_pins.cap(1);
      u_pins.cap(3);
      rd(12'h044);
      chk(r, 32'h0000_0100);
      rd(12'h04C);
      chk(r, 32'h0000_0000);
      wr(12'h048, 32'h0000_ABCD);
      rd(12'h048);
      chk(r, 32'h0000_0100);
      wr(12'h040, 32'h0000_1000);
      wr(12'h004, 32'h0000_FFFF);
      wr(12'h000, 32'h0000_0011);
      r = 32'h0000_0000;
      for (i = 0; i < 20 && r[15:12] !== 4'h1; i++) rd(12'h004);
      chk(r & 32'h0000_FFF0, 32'h0000_1000);
      wr(12'h000, 32'h0000_0018);
      wr(12'h004, 32'h0000_0005);
      u_pins.fall();
      rd(12'h004);
      chk(r, 32'h0000_1000);
      rd(12'h028);
      chk(r & 32'h0000_0002, 32'h0000_0002);
      // ------------------------------------------
      // port 5 lines from the fourth cc slot
      // ------------------------------------------
      wr(12'h01C, 32'h0000_4138);
      wr(12'h020, 32'h0000_0010);
      wr(12'h024, 32'h0000_A5FF);
      wr(12'h050, 32'h0000_0201);
      wr(12'h004, 32'h0000_0200);
      wr(12'h000, 32'h0000_0001);
      wt(13, 1'b1);
      chk(32'(port5_cmp_out), 32'h0000_00A5);
      wt(4, 1'b1);
      // ------------------------------------------
      // reset in mid-run, then both prescalers
      // ------------------------------------------
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(outs), 32'h0000_0000);
      rd(12'h050);
      chk(r, 32'h0000_0000);
      wr(12'h008, 32'h0000_0401);
      wr(12'h000, 32'h0000_0007);
      repeat (250) @(posedge pclk);
      rd(12'h00C);
      chk(r, 32'h0000_001A);
      rd(12'h004);
      chk(r, 32'h0000_0002);
      results;
   end
endmodule
